// >>> src/alsa_unit.sv
// accumulator datapath: logic, shift and add operations with sticky overflow
module alsa_unit (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // instruction from the sequencer
  input  wire logic                start_i,
  input  wire logic [5:0]          opcode_i,
  input  wire logic [29:0]         instr_i,
  input  wire logic [5:0][13:0]    index_val_i,
  input  wire logic [13:0]         loc_count_i,
  output logic                     ready_o,
  output logic                     done_o,
  output logic                     bad_op_o,
  // direct accumulator load and overflow test-and-clear
  input  wire logic                acc_load_i,
  input  wire logic [29:0]         acc_load_data_i,
  input  wire logic                ovf_clear_i,
  output logic [29:0]              acc_o,
  output logic                     ovf_o,
  // core memory operand path
  output logic                     mem_rd_o,
  output logic                     mem_wr_o,
  output logic [13:0]              mem_addr_o,
  output logic [29:0]              mem_wdata_o,
  input  wire logic                mem_rvalid_i,
  input  wire logic [29:0]         mem_rdata_i
);

  // ------------------------------------------------------------------
  // state record
  // ------------------------------------------------------------------
  typedef struct packed {
    alsa_pkg::alsa_state_e st;
    logic [29:0]           acc;
    logic                  ovf;
    logic [11:0]           cnt;
    logic [5:0]            op;
    logic [13:0]           ea;
    logic                  mem_rd;
    logic                  mem_wr;
    logic [29:0]           wdata;
    logic                  done;
    logic                  bad;
  } alsa_regs_s;

  alsa_regs_s s;
  alsa_regs_s next_s;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // a 31-bit result that leaves the signed fraction range
  function automatic logic out_of_range(input logic [30:0] sum);
    out_of_range = sum[30] ^ sum[29];
  endfunction : out_of_range

  // true when the opcode is one of the three shifts
  function automatic logic is_shift(input logic [5:0] op);
    is_shift = (op == alsa_pkg::OP_LOGICAL_SHIFT) ||
               (op == alsa_pkg::OP_ROTATE_REGISTER) ||
               (op == alsa_pkg::OP_ARITH_SHIFT);
  endfunction : is_shift

  // distance from the six-bit field; negative field means left
  function automatic logic [5:0] shift_dist(input logic [5:0] f);
    logic [5:0] neg;
    neg = 6'(~f + 6'h01);
    shift_dist = f[alsa_pkg::SH_DIR] ? neg : {1'b0, f[4:0]};
  endfunction : shift_dist

  // whole shift time in clocks, loaded as count minus one
  function automatic logic [11:0] shift_clks(input logic [5:0] f);
    logic [5:0] n;
    logic [5:0] steps;
    n = shift_dist(f);
    // one step covers two left or one right; each further two add a step
    if (f[alsa_pkg::SH_DIR]) begin
      steps = 6'((n + 6'h01) >> 1);
    end else begin
      steps = 6'((n >> 1) + 6'h01);
    end
    shift_clks = 12'(alsa_pkg::SHIFT_BASE_CLKS + alsa_pkg::STEP_CLKS * steps - 1);
  endfunction : shift_clks

  // shift result in the low 30 bits, overflow on top
  function automatic logic [30:0] shift_fn(input logic [5:0] op,
                                           input logic [29:0] a,
                                           input logic [5:0] f);
    logic        left;
    logic [5:0]  n;
    logic [4:0]  r;
    logic [59:0] dbl;
    logic [62:0] ext;
    logic [29:0] res;
    logic        v;
    left = f[alsa_pkg::SH_DIR];
    n    = shift_dist(f);
    r    = 5'(n % 6'h1E);
    ext  = {a, 33'h0};
    v    = 1'b0;
    res  = a;
    case (op)
      alsa_pkg::OP_LOGICAL_SHIFT: begin
        res = left ? (a << n) : (a >> n);
      end
      alsa_pkg::OP_ROTATE_REGISTER: begin
        // doubled word makes both rotate directions a plain shift
        if (left) begin
          dbl = {a, a} << r;
          res = dbl[59:30];
        end else begin
          dbl = {a, a} >> r;
          res = dbl[29:0];
        end
      end
      alsa_pkg::OP_ARITH_SHIFT: begin
        if (left) begin
          res = a << n;
          // every bit that passes through the sign position must match it
          for (int i = 1; i <= 32; i++) begin
            if ((6'(i) <= n) && (ext[62 - i] != a[29])) begin
              v = 1'b1;
            end
          end
        end else begin
          res = 30'($signed(a) >>> n);
        end
      end
      default: begin
        res = a;
      end
    endcase
    shift_fn = {v, res};
  endfunction : shift_fn

  // ------------------------------------------------------------------
  // effective address
  // ------------------------------------------------------------------
  logic [2:0]  sel;
  logic [13:0] base;
  logic [13:0] eff_addr;

  assign sel  = instr_i[alsa_pkg::SEL_HI:alsa_pkg::SEL_LO];
  assign base = instr_i[alsa_pkg::BASE_HI:0];

  // selector 0 plain, 1-6 index register, 7 location counter
  always_comb begin
    case (sel)
      3'h0:    eff_addr = base;
      3'h7:    eff_addr = 14'(base + loc_count_i);
      default: eff_addr = 14'(base + index_val_i[3'(sel - 3'h1)]);
    endcase
  end

  // ------------------------------------------------------------------
  // operand arithmetic, all widened by one bit for range checks
  // ------------------------------------------------------------------
  logic [30:0] acc_x;
  logic [30:0] mem_x;
  logic [30:0] mag_x;
  logic [30:0] sum_x;
  logic [30:0] msum_x;
  logic [30:0] rdif_x;
  logic [30:0] sh_res;

  // sign-extended two's complement fractions
  assign acc_x  = {s.acc[29], s.acc};
  assign mem_x  = {mem_rdata_i[29], mem_rdata_i};
  assign mag_x  = s.acc[29] ? 31'(-acc_x) : acc_x;
  assign sum_x  = 31'(acc_x + mem_x);
  assign msum_x = 31'(mag_x + mem_x);
  assign rdif_x = 31'(mem_x - acc_x);
  assign sh_res = shift_fn(s.op, s.acc, s.ea[alsa_pkg::SH_W-1:0]);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.done   = 1'b0;
    next_s.bad    = 1'b0;
    // clear first so that a same-cycle set below wins
    next_s.ovf    = s.ovf & ~ovf_clear_i;
    case (s.st)
      alsa_pkg::ST_IDLE: begin
        if (start_i) begin
          next_s.op = opcode_i;
          next_s.ea = eff_addr;
          if (is_shift(opcode_i)) begin
            // bits 16-23 only reach address bits above the shift field
            next_s.cnt = shift_clks(eff_addr[alsa_pkg::SH_W-1:0]);
            next_s.st  = alsa_pkg::ST_SHIFT;
          end else begin
            case (opcode_i)
              alsa_pkg::OP_ADD, alsa_pkg::OP_ADD_WRITE_BOTH,
              alsa_pkg::OP_ADD_TO_MAG, alsa_pkg::OP_MAG_ADD_WB,
              alsa_pkg::OP_REVERSE_DIFF, alsa_pkg::OP_DIFF_WRITE_BOTH,
              alsa_pkg::OP_OR_INTO_RESULT, alsa_pkg::OP_OR_WRITE_BOTH,
              alsa_pkg::OP_XOR_INTO_RESULT, alsa_pkg::OP_XOR_WRITE_BOTH,
              alsa_pkg::OP_OR_INTO_MEMORY: begin
                next_s.mem_rd = 1'b1;
                next_s.st     = alsa_pkg::ST_READ;
              end
              default: begin
                // codes this unit does not own finish at once, nothing touched
                next_s.done = 1'b1;
                next_s.bad  = 1'b1;
              end
            endcase
          end
        end else if (acc_load_i) begin
          next_s.acc = acc_load_data_i;
        end
      end
      alsa_pkg::ST_READ: begin
        if (mem_rvalid_i) begin
          next_s.mem_rd = 1'b0;
          next_s.mem_wr = 1'b1;
          next_s.st     = alsa_pkg::ST_WRITE;
          case (s.op)
            alsa_pkg::OP_XOR_INTO_RESULT: begin
              next_s.acc    = s.acc ^ mem_rdata_i;
              next_s.mem_wr = 1'b0;
            end
            alsa_pkg::OP_XOR_WRITE_BOTH: begin
              next_s.acc   = s.acc ^ mem_rdata_i;
              next_s.wdata = s.acc ^ mem_rdata_i;
            end
            alsa_pkg::OP_OR_INTO_RESULT: begin
              next_s.acc    = s.acc | mem_rdata_i;
              next_s.mem_wr = 1'b0;
            end
            alsa_pkg::OP_OR_WRITE_BOTH: begin
              next_s.acc   = s.acc | mem_rdata_i;
              next_s.wdata = s.acc | mem_rdata_i;
            end
            alsa_pkg::OP_OR_INTO_MEMORY: begin
              next_s.wdata = mem_rdata_i | s.acc;
            end
            alsa_pkg::OP_ADD, alsa_pkg::OP_ADD_WRITE_BOTH: begin
              // residue is simply the low 30 bits of the wide sum
              next_s.acc   = sum_x[29:0];
              next_s.wdata = sum_x[29:0];
              next_s.ovf   = next_s.ovf | out_of_range(sum_x);
              next_s.mem_wr = (s.op == alsa_pkg::OP_ADD_WRITE_BOTH);
            end
            alsa_pkg::OP_ADD_TO_MAG, alsa_pkg::OP_MAG_ADD_WB: begin
              // magnitude is never negative, so only the top can be crossed
              next_s.acc   = msum_x[29:0];
              next_s.wdata = msum_x[29:0];
              next_s.ovf   = next_s.ovf | (~msum_x[30] & msum_x[29]);
              next_s.mem_wr = (s.op == alsa_pkg::OP_MAG_ADD_WB);
            end
            alsa_pkg::OP_REVERSE_DIFF, alsa_pkg::OP_DIFF_WRITE_BOTH: begin
              next_s.acc   = rdif_x[29:0];
              next_s.wdata = rdif_x[29:0];
              next_s.ovf   = next_s.ovf | out_of_range(rdif_x);
              next_s.mem_wr = (s.op == alsa_pkg::OP_DIFF_WRITE_BOTH);
            end
            default: begin
              next_s.mem_wr = 1'b0;
            end
          endcase
          if (!next_s.mem_wr) begin
            next_s.st   = alsa_pkg::ST_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
      alsa_pkg::ST_WRITE: begin
        // memory takes the write strobe in its single cycle
        next_s.mem_wr = 1'b0;
        next_s.done   = 1'b1;
        next_s.st     = alsa_pkg::ST_IDLE;
      end
      alsa_pkg::ST_SHIFT: begin
        // the result lands only when the documented time has passed
        if (s.cnt == 12'h000) begin
          next_s.acc  = sh_res[29:0];
          next_s.ovf  = next_s.ovf | sh_res[30];
          next_s.done = 1'b1;
          next_s.st   = alsa_pkg::ST_IDLE;
        end else begin
          next_s.cnt = 12'(s.cnt - 12'h001);
        end
      end
      default: begin
        next_s.st     = alsa_pkg::ST_IDLE;
        next_s.mem_rd = 1'b0;
        next_s.mem_wr = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '{st:     alsa_pkg::ST_IDLE,
             acc:    alsa_pkg::ACC_RESET,
             ovf:    1'b0,
             cnt:    12'h000,
             op:     6'h00,
             ea:     14'h0000,
             mem_rd: 1'b0,
             mem_wr: 1'b0,
             wdata:  30'h0000_0000,
             done:   1'b0,
             bad:    1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign ready_o     = (s.st == alsa_pkg::ST_IDLE);
  assign done_o      = s.done;
  assign bad_op_o    = s.bad;
  assign acc_o       = s.acc;
  assign ovf_o       = s.ovf;
  assign mem_rd_o    = s.mem_rd;
  assign mem_wr_o    = s.mem_wr;
  assign mem_addr_o  = s.ea;
  assign mem_wdata_o = s.wdata;

endmodule : alsa_unit

// >>> shared/alsa_pkg.sv
// constants and types for the accumulator logic, shift and add unit
package alsa_pkg;

  // ------------------------------------------------------------------
  // word layout (vector bit = 29 - printed bit)
  // ------------------------------------------------------------------
  localparam int unsigned WORD_W    = 30;
  localparam int unsigned ADDR_W    = 14;
  localparam int unsigned OP_W      = 6;
  localparam int unsigned SEL_HI    = 17;   // printed bit 12
  localparam int unsigned SEL_LO    = 15;   // printed bit 14
  localparam int unsigned BASE_HI   = 13;   // printed bit 16
  localparam int unsigned SH_DIR    = 5;    // printed bit 24
  localparam int unsigned SH_W      = 6;    // printed bits 24-29
  localparam int unsigned CNT_W     = 12;

  // ------------------------------------------------------------------
  // primary operation codes (octal values as printed)
  // ------------------------------------------------------------------
  localparam logic [5:0] OP_LOGICAL_SHIFT   = 6'h01;  // octal 01
  localparam logic [5:0] OP_ROTATE_REGISTER = 6'h03;  // octal 03
  localparam logic [5:0] OP_ARITH_SHIFT     = 6'h05;  // octal 05
  localparam logic [5:0] OP_ADD             = 6'h08;  // octal 10
  localparam logic [5:0] OP_ADD_WRITE_BOTH  = 6'h09;  // octal 11
  localparam logic [5:0] OP_ADD_TO_MAG      = 6'h0A;  // octal 12
  localparam logic [5:0] OP_MAG_ADD_WB      = 6'h0B;  // octal 13
  localparam logic [5:0] OP_REVERSE_DIFF    = 6'h0C;  // octal 14
  localparam logic [5:0] OP_DIFF_WRITE_BOTH = 6'h0D;  // octal 15
  localparam logic [5:0] OP_OR_INTO_RESULT  = 6'h1A;  // octal 32
  localparam logic [5:0] OP_OR_WRITE_BOTH   = 6'h1B;  // octal 33
  localparam logic [5:0] OP_XOR_INTO_RESULT = 6'h1E;  // octal 36
  localparam logic [5:0] OP_XOR_WRITE_BOTH  = 6'h1F;  // octal 37
  localparam logic [5:0] OP_OR_INTO_MEMORY  = 6'h2B;  // octal 53

  // ------------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------------
  localparam logic [29:0] ACC_RESET      = 30'h0000_0000;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MEM_CYCLE_NS   = 1000;  // machine cycle length
  localparam int unsigned SHIFT_STEP_US  = 2;     // 2.0 us per step
  localparam int unsigned MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CLKS      =
    (SHIFT_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHIFT_BASE_CLKS = 2 * MEM_CYCLE_CLKS;

  // ------------------------------------------------------------------
  // control state
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_SHIFT = 4'h8
  } alsa_state_e;

endpackage : alsa_pkg

// >>> test/alsa_mem_model.sv
// behavioural core memory answering the unit's operand reads and writes
module alsa_mem_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // answer delay in cycles
  input  wire logic [1:0]  dly_i,
  // operand path
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [29:0] wdata_i,
  output logic             rvalid_o,
  output logic [29:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [29:0] mem [16384];
  logic [1:0]  wait_cnt;
  // ----------
  // read answer
  // ----------
  // data toggles every cycle outside the valid beat so stale reads show
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_o <= 1'b0;
      wait_cnt <= 2'h0;
      rdata_o  <= 30'h2AAAAAAA;
    end else begin
      rvalid_o <= 1'b0;
      rdata_o  <= ~rdata_o;
      if (rd_i && !rvalid_o) begin
        if (wait_cnt == dly_i) begin
          rvalid_o <= 1'b1;
          rdata_o  <= mem[addr_i];
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
      if (wr_i) mem[addr_i] <= wdata_i; // write strobe is never refused
    end
  end
endmodule : alsa_mem_model

// >>> test/alsa_unit_sva.sv
// port assertions for the accumulator logic, shift and add unit
module alsa_unit_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // sequencer side
  input wire logic        start_i,
  input wire logic [5:0]  opcode_i,
  input wire logic        acc_load_i,
  input wire logic        ovf_clear_i,
  input wire logic        ready_o,
  input wire logic        done_o,
  input wire logic        bad_op_o,
  input wire logic [29:0] acc_o,
  input wire logic        ovf_o,
  // memory side
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [13:0] mem_addr_o,
  input wire logic        mem_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic        shift_go;
  logic        sh_run;
  logic [11:0] sh_cnt;
  assign shift_go = start_i && ready_o && opcode_i inside {alsa_pkg::OP_LOGICAL_SHIFT,
    alsa_pkg::OP_ROTATE_REGISTER, alsa_pkg::OP_ARITH_SHIFT};
  // ----------
  // shift cycle counter
  // ----------
  // a counter, because the longest shift is beyond a delay range
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_run <= 1'b0;
      sh_cnt <= 12'h000;
    end else if (shift_go) begin
      sh_run <= 1'b1;
      sh_cnt <= 12'h001;
    end else if (sh_run && done_o) begin
      sh_run <= 1'b0;
    end else if (sh_run) begin
      sh_cnt <= sh_cnt + 12'h001;
    end
  end
  // ----------
  // assertions
  // ----------
  a_shift_span: assert property (sh_run && done_o |-> sh_cnt >= 12'h191)
    else $error("shift finished too early");
  a_shift_bound: assert property (sh_run |-> sh_cnt <= 12'hE11)
    else $error("shift ran too long");
  a_shift_nomem: assert property (shift_go |=> !mem_rd_o [*8])
    else $error("shift touched memory");
  a_ovf_sticky: assert property (ovf_o && !ovf_clear_i |=> ovf_o)
    else $error("overflow dropped without clear");
  // write-back ops update accumulator and overflow with the write strobe, before done
  a_ovf_rise: assert property ($rose(ovf_o) |-> (done_o && !bad_op_o) || mem_wr_o)
    else $error("overflow set outside an operation");
  a_acc_cause: assert property (!$stable(acc_o) |->
    done_o || mem_wr_o || $past(acc_load_i && ready_o && !start_i))
    else $error("accumulator changed without cause");
  a_wr_follows: assert property ($rose(mem_wr_o) |-> $past(mem_rd_o && mem_rvalid_i))
    else $error("write without a preceding read");
  a_wr_single: assert property (mem_wr_o |=> !mem_wr_o && done_o)
    else $error("write strobe not one cycle");
  a_rd_hold: assert property (mem_rd_o && !mem_rvalid_i |=> mem_rd_o && $stable(mem_addr_o))
    else $error("read request not held");
  a_rd_release: assert property (mem_rd_o && mem_rvalid_i |=> !mem_rd_o)
    else $error("read request not released");
  c_shift: cover property (sh_run && done_o);
  c_write: cover property (mem_wr_o);
  c_ovf: cover property ($rose(ovf_o));
  c_bad: cover property (bad_op_o);
endmodule : alsa_unit_sva

bind alsa_unit alsa_unit_sva i_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i),
  .opcode_i(opcode_i), .acc_load_i(acc_load_i), .ovf_clear_i(ovf_clear_i), .ready_o(ready_o),
  .done_o(done_o), .bad_op_o(bad_op_o), .acc_o(acc_o), .ovf_o(ovf_o), .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_rvalid_i(mem_rvalid_i));

// >>> test/testbench.sv
// self-checking bench for the accumulator logic, shift and add unit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // signals
  // ----------
  logic             clk_i = 1'b0;
  logic             arst_n_i = 1'b0;
  logic             start_i = 1'b0;
  logic [5:0]       opcode_i = 6'h00;
  logic [29:0]      instr_i = 30'h0;
  logic [5:0][13:0] index_val_i = {14'h3FFF, 14'h0, 14'h0, 14'h0, 14'h0100, 14'h0005};
  logic [13:0]      loc_count_i = 14'h0200;
  logic             acc_load_i = 1'b0;
  logic [29:0]      acc_load_data_i = 30'h0;
  logic             ovf_clear_i = 1'b0;
  logic             mem_rvalid_i, ready_o, done_o, bad_op_o, ovf_o, mem_rd_o, mem_wr_o;
  logic [29:0]      mem_rdata_i, acc_o, mem_wdata_o;
  logic [13:0]      mem_addr_o;
  logic [1:0]       dly = 2'h0;
  int               fails = 0;
  int               checked = 0;
  alsa_unit i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .opcode_i(opcode_i),
    .instr_i(instr_i), .index_val_i(index_val_i), .loc_count_i(loc_count_i), .ready_o(ready_o),
    .done_o(done_o), .bad_op_o(bad_op_o), .acc_load_i(acc_load_i),
    .acc_load_data_i(acc_load_data_i), .ovf_clear_i(ovf_clear_i), .acc_o(acc_o), .ovf_o(ovf_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i));
  alsa_mem_model i_mem (.clk_i(clk_i), .arst_n_i(arst_n_i), .dly_i(dly), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rvalid_o(mem_rvalid_i),
    .rdata_o(mem_rdata_i));
  always #5 clk_i = ~clk_i;
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // one start pulse, then a bounded wait for done; n counts cycles
  task automatic go(input logic [5:0] op, input logic [29:0] ins, output int n);
    @(posedge clk_i);
    start_i  <= 1'b1;
    opcode_i <= op;
    instr_i  <= ins;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (n = 1; n < 4000; n++) begin
      @(negedge clk_i);
      if (done_o === 1'b1) break;
    end
    if (n == 4000) begin
      fails++;
      summarize();
    end
  endtask : go
  // load the accumulator, optionally clearing overflow in the same cycle
  task automatic ld(input logic [29:0] v, input logic clr);
    @(posedge clk_i);
    acc_load_i      <= 1'b1;
    acc_load_data_i <= v;
    ovf_clear_i     <= clr;
    @(posedge clk_i);
    acc_load_i  <= 1'b0;
    ovf_clear_i <= 1'b0;
  endtask : ld
  // memory operation; answer delay varies with the address
  task automatic mop(input logic [5:0] op, input logic [29:0] ins, input logic [13:0] ea,
                     input logic [29:0] a0, m0, xa, xm, input logic xv, clr);
    int n;
    i_mem.mem[ea] = m0;
    dly <= ea[5:4];
    ld(a0, clr);
    go(op, ins, n);
    chk(acc_o, xa);
    chk(ovf_o, xv);
    chk(i_mem.mem[ea], xm);
  endtask : mop
  // shift with expected result, overflow and step time in microseconds, the 2 us base time not counted
  task automatic sop(input logic [5:0] op, input logic [29:0] ins, xa, input logic xv,
                     input int us);
    int n;
    go(op, ins, n);
    chk(acc_o, xa);
    chk(ovf_o, xv);
    chk(30'(n), 30'(201 + 100 * us));
  endtask : sop
  // ----------
  // main sequence
  // ----------
  initial begin
    int n;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    chk(acc_o, 30'h0);
    chk(ovf_o, 1'b0);
    chk(ready_o, 1'b1);
    mop(alsa_pkg::OP_XOR_INTO_RESULT, 30'h0010, 14'h0010, 30'h2AAAAAAA, 30'h3FFF0000,
        30'h1555AAAA, 30'h3FFF0000, 1'b0, 1'b1);
    mop(alsa_pkg::OP_XOR_WRITE_BOTH, 30'h10020, 14'h0120, 30'h0F0F0F0F, 30'h33333333,
        30'h3C3C3C3C, 30'h3C3C3C3C, 1'b0, 1'b1);
    mop(alsa_pkg::OP_OR_INTO_RESULT, 30'h38030, 14'h0230, 30'h01234567, 30'h10000001,
        30'h11234567, 30'h10000001, 1'b0, 1'b1);
    mop(alsa_pkg::OP_OR_WRITE_BOTH, 30'h30041, 14'h0040, 30'h00000F00, 30'h000000F0,
        30'h00000FF0, 30'h00000FF0, 1'b0, 1'b1);
    mop(alsa_pkg::OP_OR_INTO_MEMORY, 30'h0050, 14'h0050, 30'h20000001, 30'h2,
        30'h20000001, 30'h20000003, 1'b0, 1'b1);
    mop(alsa_pkg::OP_ADD, 30'h0060, 14'h0060, 30'h1FFFFFFF, 30'h1,
        30'h20000000, 30'h1, 1'b1, 1'b1);
    mop(alsa_pkg::OP_ADD_WRITE_BOTH, 30'h0070, 14'h0070, 30'h20000000, 30'h20000000,
        30'h0, 30'h0, 1'b1, 1'b1);
    mop(alsa_pkg::OP_ADD_TO_MAG, 30'h0080, 14'h0080, 30'h30000000, 30'h08000000,
        30'h18000000, 30'h08000000, 1'b0, 1'b1);
    mop(alsa_pkg::OP_MAG_ADD_WB, 30'h0090, 14'h0090, 30'h3FFFFFFF, 30'h1FFFFFFF,
        30'h20000000, 30'h20000000, 1'b1, 1'b1);
    mop(alsa_pkg::OP_REVERSE_DIFF, 30'h00A0, 14'h00A0, 30'h1, 30'h0,
        30'h3FFFFFFF, 30'h0, 1'b0, 1'b1);
    mop(alsa_pkg::OP_DIFF_WRITE_BOTH, 30'h00B0, 14'h00B0, 30'h20000000, 30'h0,
        30'h20000000, 30'h20000000, 1'b1, 1'b1);
    mop(alsa_pkg::OP_ADD, 30'h00C0, 14'h00C0, 30'h0, 30'h0,
        30'h0, 30'h0, 1'b1, 1'b0);
    ld(30'h310A52EF, 1'b1);
    @(negedge clk_i);
    chk(ovf_o, 1'b0);
    // indexed minus two plus five gives right three; bits 16-23 set
    sop(alsa_pkg::OP_LOGICAL_SHIFT, 30'hBFFE, 30'h06214A5D, 1'b0, 4);
    sop(alsa_pkg::OP_LOGICAL_SHIFT, 30'h3FFA, 30'h08529740, 1'b0, 6);
    sop(alsa_pkg::OP_ROTATE_REGISTER, 30'h3FCC, 30'h1D008529, 1'b0, 14);
    sop(alsa_pkg::OP_ROTATE_REGISTER, 30'h3FFD, 30'h2804294B, 1'b0, 4);
    sop(alsa_pkg::OP_ARITH_SHIFT, 30'h3FC3, 30'h3D008529, 1'b0, 4);
    sop(alsa_pkg::OP_ARITH_SHIFT, 30'h3FFD, 30'h28042948, 1'b0, 4);
    sop(alsa_pkg::OP_ARITH_SHIFT, 30'h3FFD, 30'h00214A40, 1'b1, 4);
    ld(30'h00214A40, 1'b1);
    sop(alsa_pkg::OP_ARITH_SHIFT, 30'h3FF7, 30'h02948000, 1'b1, 10);
    sop(alsa_pkg::OP_ROTATE_REGISTER, 30'h3FDF, 30'h014A4000, 1'b1, 32);
    sop(alsa_pkg::OP_ROTATE_REGISTER, 30'h3FE0, 30'h05290000, 1'b1, 32);
    go(6'h3F, 30'h0, n);
    chk(bad_op_o, 1'b1);
    chk(acc_o, 30'h05290000);
    summarize();
  end
endmodule : testbench
